/* src/register_field_access_types.sv */
module register_field_access_types
    import field_access_pkg::*;
(
    input  wire logic                  mclk,       // 25 mhz core clock
    input  wire logic                  srst,       // sync reset, high
    input  wire logic                  wr_en,      // write strobe
    input  wire field_access_pkg::wr_src_t wr_src, // write source
    input  wire logic [ADDR_W-1:0]     wr_addr,    // write word index
    input  wire logic [DATA_W-1:0]     wr_data,    // write data
    input  wire logic                  rd_en,      // read strobe
    input  wire logic [ADDR_W-1:0]     rd_addr,    // read word index
    output logic      [DATA_W-1:0]     rd_data,    // read data, registered
    input  wire logic [7:0]            hw_status,  // live ro status
    input  wire logic [7:0]            hw_event,   // w1c set pulses
    input  wire logic                  hw_count,   // rc counter increment
    input  wire logic [DATA_W-1:0]     strap_val,  // strap pin value
    input  wire logic                  init_load,  // hardware_initialized_field load pulse
    output logic                       unlocked,   // unlock bit state
    output logic      [7:0]            lock_out,   // lock field value
    output logic      [15:0]           cfg_out     // config field value
);
    import field_access_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic              unlock_r;
    logic [7:0]        rw_r;
    logic [7:0]        lock_r;
    logic [7:0]        stat_r;
    logic [7:0]        w1c_r;
    logic [7:0]        rc_r;
    logic [7:0]        rcw_r;
    logic [15:0]       cfg_r;
    logic [DATA_W-1:0] hardware_initialized_field_r;
    logic              hardware_initialized_field_done_r;
    logic              wr_ctrl, wr_stat, wr_cfg, wr_hwi;
    logic              rd_stat;
    logic [DATA_W-1:0] w_ctrl, w_stat, w_cfg;
    logic [7:0]        w1c_nxt;
    logic [7:0]        w1c_kept;

    // source is not decoded: every path gets identical treatment
    always_comb begin
        wr_ctrl = wr_en && (wr_addr == WORD_CTRL);
        wr_stat = wr_en && (wr_addr == WORD_STATUS);
        wr_cfg  = wr_en && (wr_addr == WORD_CONFIG);
        wr_hwi  = wr_en && (wr_addr == WORD_HARDWARE_INITIALIZED_FIELD);
        rd_stat = rd_en && (rd_addr == WORD_STATUS);
    end

    // ------------------------------------------------------------
    // control word: rw byte, unlock bit, lock field
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            unlock_r <= 1'b0;
            rw_r     <= RW_RST;
        end else if (wr_ctrl) begin
            unlock_r <= wr_data[UNLOCK_BIT];
            rw_r     <= wr_data[RW_HI:RW_LO];
        end
    end

    // same-cycle write of unlock and lock uses the old unlock value
    always_ff @(posedge mclk) begin
        if (srst) begin
            lock_r <= LOCK_RST;
        end else if (wr_ctrl && unlock_r) begin
            lock_r <= wr_data[LOCK_HI:LOCK_LO];
        end
    end

    // ------------------------------------------------------------
    // status word
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            stat_r <= BYTE_ZERO;
        end else begin
            stat_r <= hw_status;
        end
    end

    always_comb begin
        w1c_nxt = w1c_r;
        if (wr_stat) begin
            w1c_nxt = w1c_nxt & ~wr_data[W1C_HI:W1C_LO];
        end
        w1c_nxt = w1c_nxt | hw_event;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            w1c_r <= BYTE_ZERO;
        end else begin
            w1c_r <= w1c_nxt;
        end
    end

    // counter saturates; increment in the read cycle is kept, not lost
    always_ff @(posedge mclk) begin
        if (srst) begin
            rc_r <= BYTE_ZERO;
        end else if (rd_stat) begin
            rc_r <= hw_count ? BYTE_ONE : BYTE_ZERO;
        end else if (hw_count && (rc_r != 8'hff)) begin
            rc_r <= rc_r + BYTE_ONE;
        end
    end

    // write wins over read-clear when both land in one cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            rcw_r <= BYTE_ZERO;
        end else if (wr_stat) begin
            rcw_r <= wr_data[RCW_HI:RCW_LO];
        end else if (rd_stat) begin
            rcw_r <= BYTE_ZERO;
        end
    end

    // ------------------------------------------------------------
    // config word, gated by the write-transient qualifier
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg_r <= CFG_RST;
        end else if (wr_cfg && wr_data[WT_BIT]) begin
            cfg_r <= wr_data[CFG_HI:CFG_LO];
        end
    end

    // ------------------------------------------------------------
    // hardware initialised word
    // ------------------------------------------------------------
    // loads once after reset; software writes never reach it
    always_ff @(posedge mclk) begin
        if (srst) begin
            hardware_initialized_field_r      <= '0;
            hardware_initialized_field_done_r <= 1'b0;
        end else if (init_load && !hardware_initialized_field_done_r) begin
            hardware_initialized_field_r      <= strap_val;
            hardware_initialized_field_done_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        w_ctrl = '0;
        w_ctrl[UNLOCK_BIT]      = unlock_r;
        w_ctrl[RW_HI:RW_LO]     = rw_r;
        w_ctrl[LOCK_HI:LOCK_LO] = lock_r;
        w_stat = {rcw_r, rc_r, w1c_r, stat_r};
        w_cfg  = '0;
        w_cfg[CFG_HI:CFG_LO]    = cfg_r;
    end

    field_access_if rd_if ();
    assign rd_if.rd_en   = rd_en;
    assign rd_if.rd_addr = rd_addr;
    assign rd_if.words   = {hardware_initialized_field_r, w_cfg, w_stat, w_ctrl};

    read_mux u_read_mux (
        .mclk (mclk),
        .srst (srst),
        .port (rd_if.mux)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            rd_data  <= '0;
            unlocked <= 1'b0;
            lock_out <= LOCK_RST;
            cfg_out  <= CFG_RST;
        end else begin
            rd_data  <= rd_if.rd_data;
            unlocked <= unlock_r;
            lock_out <= lock_r;
            cfg_out  <= cfg_r;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // w1c bits that must survive, built apart from the update logic
    always_comb begin
        w1c_kept = w1c_r;
        if (wr_stat) begin
            w1c_kept = w1c_r & ~wr_data[W1C_HI:W1C_LO];
        end
    end

    a_w1c_set_wins: assert property (
        @(posedge mclk) disable iff (srst)
        |hw_event |=> (w1c_r & $past(hw_event)) == $past(hw_event))
        else $error("w1c event lost");
    a_w1c_zero_keeps: assert property (
        @(posedge mclk) disable iff (srst)
        1'b1 |=> (w1c_r & $past(w1c_kept)) == $past(w1c_kept))
        else $error("w1c bit cleared without write of one");
    a_lock_held: assert property (
        @(posedge mclk) disable iff (srst)
        !unlock_r |=> $stable(lock_r))
        else $error("lock field changed while locked");
    a_wt_gates_cfg: assert property (
        @(posedge mclk) disable iff (srst)
        !(wr_cfg && wr_data[WT_BIT]) |=> $stable(cfg_r))
        else $error("config changed without qualifier");
    a_rcw_read_clr: assert property (
        @(posedge mclk) disable iff (srst)
        (rd_stat && !wr_stat) |=> rcw_r == BYTE_ZERO)
        else $error("rcw not cleared on read");
    a_rcw_write: assert property (
        @(posedge mclk) disable iff (srst)
        wr_stat |=> rcw_r == $past(wr_data[RCW_HI:RCW_LO]))
        else $error("rcw write not loaded");
    a_rc_no_write: assert property (
        @(posedge mclk) disable iff (srst)
        (wr_stat && !rd_stat && !hw_count) |=> $stable(rc_r))
        else $error("rc field moved on write");
    a_rc_read_clr: assert property (
        @(posedge mclk) disable iff (srst)
        (rd_stat && !hw_count) |=> rc_r == BYTE_ZERO)
        else $error("rc not cleared on read");
    a_hardware_initialized_field_once: assert property (
        @(posedge mclk) disable iff (srst)
        hardware_initialized_field_done_r |=> $stable(hardware_initialized_field_r))
        else $error("hardware_initialized_field changed after load");
    a_hardware_initialized_field_no_wr: assert property (
        @(posedge mclk) disable iff (srst)
        (wr_hwi && !init_load) |=> $stable(hardware_initialized_field_r))
        else $error("hardware_initialized_field moved on software write");
    a_rw_readback: assert property (
        @(posedge mclk) disable iff (srst)
        wr_ctrl |=> rw_r == $past(wr_data[RW_HI:RW_LO]))
        else $error("rw field not updated");
    a_cfg_zero_bits: assert property (
        @(posedge mclk) disable iff (srst)
        (rd_en && rd_addr == WORD_CONFIG)
            |-> ##2 rd_data[DATA_W-1:CFG_HI+1] == '0)
        else $error("config zero bits read non-zero");
    a_ro_ignores: assert property (
        @(posedge mclk) disable iff (srst)
        1'b1 |=> stat_r == $past(hw_status))
        else $error("ro status not tracking hardware");
endmodule

/* src/field_access_pkg.sv */
package field_access_pkg;
    // ------------------------------------------------------------
    // register word layout
    // ------------------------------------------------------------
    localparam int  DATA_W      = 32;
    localparam int  ADDR_W      = 2;
    localparam int  NUM_WORDS   = 4;
    // word indices
    localparam logic [1:0] WORD_CTRL   = 2'h0; // control and lock fields
    localparam logic [1:0] WORD_STATUS = 2'h1; // status: ro, w1c, rc, rcw
    localparam logic [1:0] WORD_CONFIG = 2'h2; // rw word, qualified by wt
    localparam logic [1:0] WORD_HARDWARE_INITIALIZED_FIELD = 2'h3; // hardware initialised
    // control word fields
    localparam int  UNLOCK_BIT  = 0;           // register_unlock_bit
    localparam int  RW_LO       = 8;           // plain rw byte
    localparam int  RW_HI       = 15;
    localparam int  LOCK_LO     = 16;          // lock_protected_field
    localparam int  LOCK_HI     = 23;
    // status word fields
    localparam int  STAT_LO     = 0;           // read-only hw status
    localparam int  STAT_HI     = 7;
    localparam int  W1C_LO      = 8;           // write-one-to-clear
    localparam int  W1C_HI      = 15;
    localparam int  RC_LO       = 16;          // read-to-clear counter
    localparam int  RC_HI       = 23;
    localparam int  RCW_LO      = 24;          // read_clear_writable_field
    localparam int  RCW_HI      = 31;
    // config word fields
    localparam int  WT_BIT      = 31;          // write_transient_qualifier
    localparam int  CFG_LO      = 0;
    localparam int  CFG_HI      = 15;
    // reset values
    localparam logic [7:0]  RW_RST   = 8'h00;
    localparam logic [7:0]  LOCK_RST = 8'h00;
    localparam logic [15:0] CFG_RST  = 16'h0000;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;
    localparam logic [7:0]  BYTE_ONE  = 8'h01;
    // write sources, all treated alike
    typedef enum logic [1:0] {
        SRC_ROOT   = 2'b00,
        SRC_SMBUS  = 2'b01,
        SRC_EEPROM = 2'b10
    } wr_src_t;
endpackage

/* src/field_access_if.sv */
interface field_access_if
    import field_access_pkg::*;
();
    logic                  rd_en;   // read strobe
    logic [ADDR_W-1:0]     rd_addr; // word index
    logic [DATA_W-1:0]     rd_data; // registered read data
    logic [NUM_WORDS*DATA_W-1:0] words; // live register words
    modport host (output rd_en, output rd_addr, output words,
                  input rd_data);
    modport mux  (input rd_en, input rd_addr, input words,
                  output rd_data);
endinterface

/* src/read_mux.sv */
module read_mux
    import field_access_pkg::*;
(
    input  wire logic     mclk, // core clock
    input  wire logic     srst, // sync reset
    field_access_if.mux   port  // read path
);
    logic [DATA_W-1:0] word_sel;

    always_comb begin
        word_sel = port.words[port.rd_addr*DATA_W +: DATA_W];
    end

    // read data registered so the top output comes from a flop
    always_ff @(posedge mclk) begin
        if (srst) begin
            port.rd_data <= '0;
        end else if (port.rd_en) begin
            port.rd_data <= word_sel;
        end
    end
endmodule

/* dv/register_field_access_types_tb.sv */
module register_field_access_types_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import field_access_pkg::*;

    logic              mclk, srst, wr_en, rd_en, hw_count, init_load;
    logic              unlocked;
    wr_src_t           wr_src;
    logic [ADDR_W-1:0] wr_addr, rd_addr;
    logic [DATA_W-1:0] wr_data, rd_data, strap_val;
    logic [7:0]        hw_status, hw_event, lock_out;
    logic [15:0]       cfg_out;
    int                n_errors, checked, cycles, nsrc;
    // bench copy of every field
    logic              unl, hwl;
    logic [7:0]        rwb, lck, w1c, rc, read_clear_writable_field, stat;
    logic [15:0]       cfg;
    logic [31:0]       hwi;
    logic [31:0]       ctl_seq [5] = '{32'h00ff_5a00, 32'h0000_0001,
        32'h00c3_a501, 32'h0011_0000, 32'h0022_0000};

    register_field_access_types uut (.mclk(mclk), .srst(srst),
        .wr_en(wr_en), .wr_src(wr_src), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .hw_status(hw_status), .hw_event(hw_event),
        .hw_count(hw_count), .strap_val(strap_val),
        .init_load(init_load), .unlocked(unlocked),
        .lock_out(lock_out), .cfg_out(cfg_out));

    // ------------------------------------------------------------
    // clock, timeout, verdict
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // whole run needs well under 3000 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            test_done();
        end
    end

    task test_done;
        if (n_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        checked++;
        if (seen !== ex) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, ex, seen);
        end
    endtask

    // ------------------------------------------------------------
    // expectation helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] exp_word(input logic [1:0] a);
        case (a)
            WORD_CTRL:   return {8'h00, lck, rwb, 7'h00, unl};
            WORD_STATUS: return {read_clear_writable_field, rc, w1c, stat};
            WORD_CONFIG: return {16'h0000, cfg};
            default:     return hwl ? hwi : 32'h0000_0000;
        endcase
    endfunction

    // software keeps zero fields at zero when writing
    function automatic logic [31:0] msk(input logic [1:0]  a,
                                        input logic [31:0] d);
        if (a == WORD_CTRL) return d & 32'h00ff_ff01;
        if (a == WORD_CONFIG) return d & 32'h8000_ffff;
        return d;
    endfunction

    // ------------------------------------------------------------
    // drivers, inputs change on the falling edge
    // ------------------------------------------------------------
    task do_reset;
        @(negedge mclk);
        srst = 1'b1;
        hw_status = 8'h00;
        repeat (4) @(negedge mclk);
        srst = 1'b0;
        {unl, hwl, rwb, lck, w1c, rc, read_clear_writable_field, stat, cfg, hwi} = '0;
    endtask

    task cyc(input logic we, input logic [1:0] a, input logic [31:0] d,
             input logic [7:0] ev, input logic cnt);
        logic [7:0] st;
        st = 8'($urandom);
        @(negedge mclk);
        wr_en = we;
        wr_addr = a;
        wr_data = d;
        wr_src = wr_src_t'(nsrc % 3);
        nsrc++;
        hw_event = ev;
        hw_count = cnt;
        hw_status = st;
        @(negedge mclk);
        {wr_en, hw_event, hw_count} = '0;
        stat = st;
        if (we && a == WORD_CTRL) begin
            if (unl) lck = d[23:16];
            unl = d[0];
            rwb = d[15:8];
        end
        if (we && a == WORD_STATUS) begin
            w1c = w1c & ~d[15:8];
            read_clear_writable_field = d[31:24];
        end
        if (we && a == WORD_CONFIG && d[31]) cfg = d[15:0];
        w1c = w1c | ev;
        if (cnt && rc != 8'hff) rc = rc + 8'h01;
    endtask

    task rd(input logic [1:0] a);
        logic [31:0] e;
        e = exp_word(a);
        @(negedge mclk);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge mclk);
        rd_en = 1'b0;
        if (a == WORD_STATUS) {rc, read_clear_writable_field} = '0;
        repeat (2) @(negedge mclk);
        chk("rd_data", rd_data, e);
        chk("unlocked", {31'h0, unlocked}, {31'h0, unl});
        chk("lock_out", {24'h0, lock_out}, {24'h0, lck});
        chk("cfg_out", {16'h0, cfg_out}, {16'h0, cfg});
    endtask

    // read, write and count on the status word in one cycle
    task rd_wr(input logic [31:0] d, input logic cnt);
        logic [31:0] e;
        e = exp_word(WORD_STATUS);
        @(negedge mclk);
        {rd_en, wr_en, hw_count} = {1'b1, 1'b1, cnt};
        {rd_addr, wr_addr, wr_data} = {WORD_STATUS, WORD_STATUS, d};
        @(negedge mclk);
        {rd_en, wr_en, hw_count} = '0;
        w1c = w1c & ~d[15:8];
        {read_clear_writable_field, rc} = {d[31:24], 7'h00, cnt};
        repeat (2) @(negedge mclk);
        chk("rd_data", rd_data, e);
    endtask

    task init(input logic [31:0] v);
        @(negedge mclk);
        init_load = 1'b1;
        strap_val = v;
        @(negedge mclk);
        init_load = 1'b0;
        if (!hwl) hwi = v;
        hwl = 1'b1;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {srst, wr_en, rd_en, hw_count, init_load} = 5'h10;
        {wr_addr, rd_addr, wr_data, strap_val, hw_status, hw_event} = '0;
        wr_src = SRC_ROOT;
        void'($urandom(50));
        do_reset();
        for (int a = 0; a < 4; a++) rd(2'(a));
        // locked, unlock, unlocked write, relock, ignored write
        foreach (ctl_seq[i]) begin
            cyc(1'b1, WORD_CTRL, ctl_seq[i], 8'h00, 1'b0);
            rd(WORD_CTRL);
        end
        cyc(1'b1, WORD_STATUS, 32'h0000_0000, 8'hf0, 1'b0);
        cyc(1'b1, WORD_STATUS, 32'h0000_3000, 8'h00, 1'b0);
        // set and clear of the same bit in one cycle
        cyc(1'b1, WORD_STATUS, 32'h0000_c000, 8'h80, 1'b0);
        rd(WORD_STATUS);
        repeat (300) cyc(1'b0, WORD_CTRL, 32'h0, 8'h00, 1'b1);
        rd(WORD_STATUS);
        cyc(1'b1, WORD_STATUS, 32'h5aff_0000, 8'h00, 1'b0);
        rd(WORD_STATUS);
        rd(WORD_STATUS);
        // write wins over read-clear, count in the read cycle kept
        rd_wr(32'h3cff_ff00, 1'b1);
        rd(WORD_STATUS);
        cyc(1'b1, WORD_CONFIG, 32'h0000_1234, 8'h00, 1'b0);
        rd(WORD_CONFIG);
        cyc(1'b1, WORD_CONFIG, 32'h8000_beef, 8'h00, 1'b0);
        rd(WORD_CONFIG);
        // hardware_initialized_field loads once, ignores writes, reloads only after reset
        init(32'h1357_9bdf);
        init(32'h0246_8ace);
        cyc(1'b1, WORD_HARDWARE_INITIALIZED_FIELD, 32'hffff_ffff, 8'h00, 1'b0);
        rd(WORD_HARDWARE_INITIALIZED_FIELD);
        do_reset();
        rd(WORD_HARDWARE_INITIALIZED_FIELD);
        init(32'h0246_8ace);
        rd(WORD_HARDWARE_INITIALIZED_FIELD);
        repeat (250) begin
            logic [1:0] a;
            a = 2'($urandom);
            if ($urandom_range(3) == 0)
                rd(a);
            else
                cyc(1'($urandom), a, msk(a, $urandom),
                    ($urandom_range(3) == 0) ? 8'($urandom) : 8'h00,
                    1'($urandom));
        end
        test_done();
    end
endmodule
